// [sct_edge_sync.sv]
// Two-flop synchroniser with a rising-edge pulse.
// Assumes the input is asynchronous to CLK_I; pulse lasts one cycle.
`timescale 1ns/100ps
`default_nettype none
module sct_edge_sync
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Async level in, synchronous pulse out
  input wire logic async_i,
  output logic rise_o
);

  logic meta;
  logic stable;
  logic prev;

  // ************************************************************
  // Synchronise then detect the rising edge
  // ************************************************************
  // First flop feeds only the second one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= async_i;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edge seen on the settled copy only
  assign rise_o = stable & ~prev;

endmodule
`default_nettype wire

// [sct_pkg.sv]
// Constants for the split capture timer: control register map,
// field positions, reset value and clock prescale counts.
// Assumes a single system clock domain and an 8-bit special-function bus.
package sct_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_PAGE = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h91;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ************************************************************
  // Control register field positions
  // ************************************************************
  localparam int HIGH_FLAG_BIT = 7;
  localparam int LOW_FLAG_BIT = 6;
  localparam int LOW_IRQ_EN_BIT = 5;
  localparam int CAPTURE_EN_BIT = 4;
  localparam int SPLIT_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int ALT_SEL_MSB = 1;
  localparam int ALT_SEL_LSB = 0;

  // ************************************************************
  // Alternate clock select codes
  // ************************************************************
  localparam logic [1:0] ALT_DIV12 = 2'h0;
  localparam logic [1:0] ALT_EXT8 = 2'h1;
  localparam logic [1:0] ALT_RESERVED = 2'h2;
  localparam logic [1:0] ALT_CMP = 2'h3;

  // ************************************************************
  // Prescale counts
  // ************************************************************
  localparam int SYS_DIV = 12;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam int EXT_DIV = 8;
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_MAX = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage

// [sct_timer.sv]
// Split capture timer: control register, counter, reload and capture.
// Assumes synchronous bus inputs on CLK_I and asynchronous alternate sources.
// How it works
// - High byte rollover sets high overflow flag
// - 16-bit wrap sets high overflow flag
// - High flag with irq enable raises request
// - Low byte rollover always sets low flag
// - Flags cleared only by software writes
// - Low flag raises request when enabled
// - Capture enable bit selects capture mode
// - Split bit picks 16-bit or two 8-bit
// - 16-bit counting only while run bit set
// - In split, run gates high byte only
// - Both bytes share one alternate source
// - Per-byte select: system or alternate clock
// - Alternate sources synchronised before use
// - Decode alternate clock and capture trigger
// - Control at page 0, 0x91, resets zero
// - 16-bit overflow loads reload value, zero if capture enabled
// - Capture copies count, sets high flag
// - Split bytes reload from own reload byte
// - Select 1 is system clock, 0 alternate
`timescale 1ns/100ps
`default_nettype none
module sct_timer
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Special-function register bus
  input wire logic [7:0] SFR_PAGE_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // Clock configuration and global interrupt enable
  input wire logic HIGH_BYTE_SYSTEM_CLOCK_SELECT_I,
  input wire logic LOW_BYTE_SYSTEM_CLOCK_SELECT_I,
  input wire logic TIMER_IRQ_ENABLE_I,
  // Alternate sources
  input wire logic EXT_OSC_I,
  input wire logic COMPARATOR1_I,
  // Reload load from software
  input wire logic RELOAD_LOAD_I,
  input wire logic [15:0] RELOAD_VALUE_I,
  // Timer state and interrupt
  output logic [15:0] COUNT_O,
  output logic [15:0] RELOAD_O,
  output logic IRQ_O
);

  logic [7:0] ctrl;
  logic [15:0] count;
  logic [15:0] reload;
  logic [3:0] div12_cnt;
  logic [2:0] ext_cnt;
  logic ext_rise;
  logic cmp_rise;
  logic div12_tick;
  logic ext8_tick;
  logic alt_tick;
  logic cap_tick;
  logic tick_low;
  logic tick_high;
  logic ctrl_wr;
  logic set_high;
  logic set_low;
  logic capture;
  logic next_irq;
  logic high_flag;
  logic low_flag;
  logic low_byte_irq_enable;
  logic capture_enable;
  logic split_mode_select;
  logic run_control;
  logic [1:0] alt_clock_select;

  assign high_flag = ctrl[HIGH_FLAG_BIT];
  assign low_flag = ctrl[LOW_FLAG_BIT];
  assign low_byte_irq_enable = ctrl[LOW_IRQ_EN_BIT];
  assign capture_enable = ctrl[CAPTURE_EN_BIT];
  assign split_mode_select = ctrl[SPLIT_BIT];
  assign run_control = ctrl[RUN_BIT];
  assign alt_clock_select = ctrl[ALT_SEL_MSB:ALT_SEL_LSB];

  // ************************************************************
  // Alternate clock sources
  // ************************************************************
  // Synchronised edges of the outside sources
  sct_edge_sync u_ext_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .async_i(EXT_OSC_I),
    .rise_o(ext_rise)
  );

  sct_edge_sync u_cmp_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .async_i(COMPARATOR1_I),
    .rise_o(cmp_rise)
  );

  // System clock divided by twelve
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      div12_cnt <= 4'h0;
    else if (div12_cnt == SYS_DIV_LAST)
      div12_cnt <= 4'h0;
    else
      div12_cnt <= div12_cnt + 4'h1;
  end

  // External oscillator edges divided by eight
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      ext_cnt <= 3'h0;
    else if (ext_rise)
      ext_cnt <= ext_cnt + 3'h1;
  end

  assign div12_tick = (div12_cnt == SYS_DIV_LAST);
  assign ext8_tick = ext_rise && (ext_cnt == EXT_DIV_LAST);

  // Source and capture trigger decode
  always_comb
  begin
    unique case (alt_clock_select)
      ALT_DIV12:
      begin
        alt_tick = div12_tick;
        cap_tick = cmp_rise;
      end
      ALT_EXT8:
      begin
        alt_tick = ext8_tick;
        cap_tick = ext8_tick;
      end
      ALT_CMP:
      begin
        alt_tick = cmp_rise;
        cap_tick = ext8_tick;
      end
      ALT_RESERVED:
      begin
        alt_tick = 1'b0;
        cap_tick = 1'b0;
      end
    endcase
  end

  // Per-byte choice; both bytes share alt_tick
  assign tick_low = LOW_BYTE_SYSTEM_CLOCK_SELECT_I ? 1'b1 : alt_tick;
  assign tick_high = HIGH_BYTE_SYSTEM_CLOCK_SELECT_I ? 1'b1 : alt_tick;

  // ************************************************************
  // Counter, reload and capture
  // ************************************************************
  // Capture is snapshot of the count on the trigger
  assign capture = capture_enable && cap_tick;

  // Overflow events
  always_comb
  begin
    set_high = capture;
    set_low = 1'b0;
    if (split_mode_select)
    begin
      set_low = tick_low && (count[7:0] == BYTE_MAX);
      set_high = set_high || (run_control && tick_high && (count[15:8] == BYTE_MAX));
    end
    else if (run_control && tick_low)
    begin
      set_low = (count[7:0] == BYTE_MAX);
      set_high = set_high || (count == WORD_MAX);
    end
  end

  // Count register
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      count <= WORD_ZERO;
    else if (split_mode_select)
    begin
      // Low byte free-running, high byte gated by run
      if (tick_low)
        count[7:0] <= (count[7:0] == BYTE_MAX) ? reload[7:0] : count[7:0] + 8'h01;
      if (run_control && tick_high)
        count[15:8] <= (count[15:8] == BYTE_MAX) ? reload[15:8] : count[15:8] + 8'h01;
    end
    else if (run_control && tick_low)
    begin
      if (count == WORD_MAX)
        count <= capture_enable ? WORD_ZERO : reload;
      else
        count <= count + 16'h0001;
    end
  end

  // Reload register; capture wins over a software load
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      reload <= WORD_ZERO;
    else if (capture)
      reload <= count;
    else if (RELOAD_LOAD_I)
      reload <= RELOAD_VALUE_I;
  end

  // ************************************************************
  // Control register
  // ************************************************************
  assign ctrl_wr = SFR_WR_I && (SFR_PAGE_I == CTRL_PAGE) && (SFR_ADDR_I == CTRL_ADDR);

  // Software write; hardware set wins over a clear
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      ctrl <= CTRL_RESET;
    else
    begin
      if (ctrl_wr)
        ctrl <= SFR_WDATA_I;
      if (set_high)
        ctrl[HIGH_FLAG_BIT] <= 1'b1;
      if (set_low)
        ctrl[LOW_FLAG_BIT] <= 1'b1;
    end
  end

  // Read data, zero for other addresses
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      SFR_RDATA_O <= 8'h00;
    else if (SFR_RD_I && (SFR_PAGE_I == CTRL_PAGE) && (SFR_ADDR_I == CTRL_ADDR))
      SFR_RDATA_O <= ctrl;
    else
      SFR_RDATA_O <= 8'h00;
  end

  // ************************************************************
  // Interrupt request
  // ************************************************************
  assign next_irq = TIMER_IRQ_ENABLE_I && (high_flag || (low_byte_irq_enable && low_flag));

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= next_irq;
  end

  assign COUNT_O = count;
  assign RELOAD_O = reload;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  chk_wrap_reload: assert property (
    (!split_mode_select && run_control && tick_low && count == WORD_MAX && !capture_enable
     && !capture) |=> (count == $past(reload)) && high_flag)
    else $error("16-bit wrap did not reload or flag");

  chk_high_set: assert property (
    (!split_mode_select && run_control && tick_low && count == WORD_MAX) |=> high_flag)
    else $error("16-bit wrap did not set high flag");

  chk_split_high: assert property (
    (split_mode_select && run_control && tick_high && count[15:8] == BYTE_MAX)
    |=> high_flag && count[15:8] == $past(reload[15:8]))
    else $error("high byte rollover missed");

  chk_low_set: assert property (
    (tick_low && count[7:0] == BYTE_MAX && (split_mode_select || run_control)) |=> low_flag)
    else $error("low byte rollover did not set low flag");

  chk_flag_sticky: assert property (
    (high_flag && !ctrl_wr) |=> high_flag)
    else $error("high flag cleared without a write");

  chk_irq_high: assert property (
    (TIMER_IRQ_ENABLE_I && high_flag) |=> IRQ_O)
    else $error("no request for high flag");

  chk_irq_low: assert property (
    (TIMER_IRQ_ENABLE_I && low_byte_irq_enable && low_flag) |=> IRQ_O)
    else $error("no request for low flag");

  chk_capture_copy: assert property (
    (capture_enable && cap_tick) |=> (reload == $past(count)) && high_flag)
    else $error("capture did not copy count");

  chk_hold_stop: assert property (
    (!split_mode_select && !run_control) |=> count == $past(count))
    else $error("count moved while stopped");

  chk_split_low_free: assert property (
    (split_mode_select && !run_control && tick_low) |=> count[7:0] != $past(count[7:0])
    && count[15:8] == $past(count[15:8]))
    else $error("split low byte did not run alone");

  chk_reserved_quiet: assert property (
    (alt_clock_select == ALT_RESERVED) |-> !alt_tick && !cap_tick)
    else $error("reserved code produced edges");

  chk_system_clock_sel: assert property (
    LOW_BYTE_SYSTEM_CLOCK_SELECT_I |-> tick_low)
    else $error("system clock select not honoured");

  cov_capture: cover property (capture);
  cov_split_wrap: cover property (split_mode_select && set_low && set_high);
  cov_wrap16: cover property (!split_mode_select && !capture_enable && set_high);
  cov_set_on_clear: cover property (ctrl_wr && !SFR_WDATA_I[HIGH_FLAG_BIT] && set_high);

endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the split capture timer control block.
// Assumes sct_pkg and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sct_pkg::*;
;
  // ************************************************************
  // Signals and instance
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pg = 8'h00;
  logic [7:0] ad = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic sel_h = 1'b1;
  logic sel_l = 1'b1;
  logic irq_en = 1'b0;
  logic ext = 1'b0;
  logic cmp = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ldv = 16'h0000;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic irq;
  logic [7:0] rv;
  logic [15:0] c0;
  logic [15:0] d;
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;

  sct_timer dut (.CLK_I(clk), .RST_I(rst), .SFR_PAGE_I(pg), .SFR_ADDR_I(ad),
    .SFR_WR_I(wr_s), .SFR_RD_I(rd_s), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdata),
    .HIGH_BYTE_SYSTEM_CLOCK_SELECT_I(sel_h), .LOW_BYTE_SYSTEM_CLOCK_SELECT_I(sel_l),
    .TIMER_IRQ_ENABLE_I(irq_en), .EXT_OSC_I(ext), .COMPARATOR1_I(cmp),
    .RELOAD_LOAD_I(ld), .RELOAD_VALUE_I(ldv), .COUNT_O(cnt), .RELOAD_O(rld),
    .IRQ_O(irq));

  // Clock and cycle ceiling
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt > 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
  endtask

  // One write, taken at the second edge
  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    pg <= p;
    ad <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // One read; data taken at the edge after the taken edge
  task automatic rd(input logic [7:0] p, input logic [7:0] a);
    @(posedge clk);
    pg <= p;
    ad <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    rv = rdata;
  endtask

  task automatic load(input logic [15:0] v);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= v;
    @(posedge clk);
    ld <= 1'b0;
    @(posedge clk);
    chk(rld === v, "reload value");
  endtask

  // Rising edges on one alternate source
  task automatic pulses(input bit on_cmp, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (on_cmp) cmp <= 1'b1;
      else ext <= 1'b1;
      cyc(2);
      cmp <= 1'b0;
      ext <= 1'b0;
      cyc(2);
    end
    cyc(5);
  endtask

  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n)
    begin
      @(posedge clk);
      i++;
    end
    chk(irq === 1'b1, "no interrupt");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    do_reset();
    rd(8'h00, 8'h91);
    chk(rv === CTRL_RESET && cnt === 16'h0000 && irq === 1'b0, "reset state");
    wr(8'h00, 8'h91, 8'h3b);
    wr(8'h01, 8'h91, 8'hff);
    rd(8'h00, 8'h91);
    chk(rv === 8'h3b, "readback or wrong page write");
    rd(8'h00, 8'h92);
    chk(rv === 8'h00, "unmapped read");
    // Mid-run reset, then a stopped 16-bit timer
    do_reset();
    wr(8'h00, 8'h91, 8'h00);
    cyc(20);
    chk(cnt === 16'h0000, "count moved while stopped");
    load(16'hfef0);
    // Split, run off: low byte runs alone and reloads
    wr(8'h00, 8'h91, 8'h08);
    cyc(262);
    chk(cnt[15:8] === 8'h00 && cnt[7:0] >= 8'hf0, "split low only");
    rd(8'h00, 8'h91);
    chk(rv[7:6] === 2'b01, "low flag only");
    irq_en <= 1'b1;
    cyc(3);
    chk(irq === 1'b0, "irq without low enable");
    wr(8'h00, 8'h91, 8'h68);
    cyc(2);
    chk(irq === 1'b1, "low byte irq");
    // Split, running: high byte wraps to its reload byte
    wr(8'h00, 8'h91, 8'h0c);
    // Let the low byte request drop first
    cyc(2);
    wait_irq(300);
    chk(cnt[15:8] >= 8'hfe, "high reload byte");
    rd(8'h00, 8'h91);
    chk(rv[7] === 1'b1, "high flag split");
    // 16-bit wrap loads the reload pair
    irq_en <= 1'b0;
    cyc(2);
    // Stop the split high byte so the flag clear holds
    wr(8'h00, 8'h91, 8'h08);
    wr(8'h00, 8'h91, 8'h04);
    irq_en <= 1'b1;
    wait_irq(600);
    chk(cnt >= 16'hfef0 && cnt <= 16'hfef3, "16-bit reload");
    rd(8'h00, 8'h91);
    chk(rv[7:6] === 2'b11, "both flags on 16-bit wrap");
    // Alternate sources, reserved code first
    sel_l <= 1'b0;
    sel_h <= 1'b0;
    wr(8'h00, 8'h91, 8'h16);
    // A divided tick may still land on the write edge
    cyc(1);
    c0 = cnt;
    pulses(1'b0, 16);
    pulses(1'b1, 4);
    chk(cnt === c0 && rld === 16'hfef0, "reserved code");
    wr(8'h00, 8'h91, 8'h04);
    c0 = cnt;
    cyc(120);
    d = cnt - c0;
    chk(d >= 16'h0009 && d <= 16'h000b, "system_clock div 12");
    wr(8'h00, 8'h91, 8'h05);
    // A divided tick may still land on the write edge
    cyc(1);
    c0 = cnt;
    pulses(1'b0, 16);
    chk(cnt - c0 === 16'h0002, "ext div 8");
    wr(8'h00, 8'h91, 8'h07);
    c0 = cnt;
    pulses(1'b1, 3);
    chk(cnt - c0 === 16'h0003, "comparator clock");
    // Split: both bytes share the alternate source
    load(16'h0000);
    wr(8'h00, 8'h91, 8'h0f);
    c0 = cnt;
    pulses(1'b1, 3);
    d = cnt - c0;
    chk(cnt[7:0] - c0[7:0] === 8'h03 && cnt[15:8] - c0[15:8] === 8'h03, "shared");
    sel_h <= 1'b1;
    c0 = cnt;
    cyc(20);
    chk(cnt[7:0] === c0[7:0] && cnt[15:8] !== c0[15:8], "per-byte select");
    // Capture on a comparator edge
    sel_l <= 1'b1;
    wr(8'h00, 8'h91, 8'h14);
    pulses(1'b1, 1);
    d = cnt - rld;
    chk(rld !== 16'h0000 && d < 16'h0010, "capture snapshot");
    rd(8'h00, 8'h91);
    chk(rv[7] === 1'b1, "capture sets high flag");
    tally_and_finish();
  end
endmodule
`default_nettype wire
